/* File: dv/sosc_props.sv */
// Checker for the standby and output-state controller link and pins.
// Assumes it sits beside the link interface, with device outputs wired in.
`timescale 1ns/1ps
module sosc_props #(
  parameter int HCOUNT_W   = 16,  // Horizontal counter width
  parameter int SETTLE_CYC = 20   // Wake-up settle wait in cycles
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // Link signals
  input wire logic                wr_valid,
  input wire logic [11:0]         wr_addr,
  input wire logic [27:0]         wr_data,
  input wire logic                line_sync,
  input wire logic                frame_sync,
  // Device outputs
  input wire logic [5:0]          hclk_out,
  input wire logic [5:0]          hclk_oe_n,
  input wire logic [13:0]         pixel_data,
  input wire logic                afe_on,
  input wire logic                ref_nodes_on,
  input wire logic                core_on,
  input wire logic                ref_buffer_on,
  input wire logic [HCOUNT_W-1:0] hcount
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] stby, next_stby;    // Shadow of the standby field
  logic [1:0] stby_d;             // Shadow one cycle older
  logic [3:0] quiet, next_quiet;  // Edges since the last sync fall
  int         settle, next_settle; // Cycles left of the wake-up wait
  logic       line_d, frame_d;    // Previous sync levels
  // Shadow state follows link writes; settle wait armed on leaving shutdown
  always_comb begin
    next_stby = stby;
    next_settle = (settle > 0) ? settle - 1 : 0;
    next_quiet = (quiet == 4'hf) ? quiet : quiet + 4'h1;
    if (wr_valid && wr_addr == 12'h000) begin
      next_stby = wr_data[1:0];
      if (stby[1] && !wr_data[1]) begin
        next_settle = SETTLE_CYC - 1;
      end
    end
    if ((line_d && !line_sync) || (frame_d && !frame_sync)) begin
      next_quiet = 4'h0;
    end
  end
  // Register the shadow state; reset matches the device defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stby    <= 2'h3;
      stby_d  <= 2'h3;
      settle  <= 0;
      quiet   <= 4'h0;
      line_d  <= 1'b1;
      frame_d <= 1'b1;
    end else begin
      stby    <= next_stby;
      stby_d  <= stby;
      settle  <= next_settle;
      quiet   <= next_quiet;
      line_d  <= line_sync;
      frame_d <= frame_sync;
    end
  end
  a_shutdown_hiz: assert property (stby[1] |=>
    hclk_oe_n == 6'h3f && pixel_data == 14'h0000)
    else $error("shutdown pins not released");
  a_power_decode: assert property (afe_on == (stby == 2'h0) &&
    ref_nodes_on == !stby[1] && (!stby[1] || !core_on))
    else $error("power state decode wrong");
  a_refstby_idle: assert property (stby == 2'h1 |=>
    hclk_oe_n == 6'h00 && hclk_out == 6'h0a && pixel_data == 14'h0000)
    else $error("reference standby idle levels wrong");
  a_line_order: assert property ($fell(line_sync) |-> !frame_sync)
    else $error("line sync fell before frame sync");
  a_hcount_restart: assert property ($fell(line_sync) |-> ##12
    hcount == '0)
    else $error("horizontal counter not restarted");
  a_wake_settle: assert property (wr_valid && wr_addr == 12'h014 &&
    wr_data[0] |-> settle == 0)
    else $error("core restart inside settle wait");
  a_restart_core: assert property (wr_valid && wr_addr == 12'h014 &&
    wr_data[0] && !stby[1] |=> core_on)
    else $error("core not started by restart");
  a_stop_core: assert property (wr_valid && wr_addr == 12'h014 &&
    !wr_data[0] |=> !core_on)
    else $error("core not stopped by restart 0");
  a_refbuf_ctrl: assert property (wr_valid && wr_addr == 12'h000 |=>
    ref_buffer_on == (!$past(wr_data[2]) && !$past(wr_data[1])))
    else $error("reference buffer control wrong");
  a_enable_sync: assert property (stby == 2'h0 && stby_d == 2'h0 &&
    core_on && $past(core_on) &&
    quiet > 4'h5 && hclk_out == 6'h0a |=> hclk_out == 6'h0a)
    else $error("drive enable applied without sync fall");
  c_line_fall: cover property ($fell(line_sync) && stby == 2'h0);
  c_restart: cover property (wr_valid && wr_addr == 12'h014 && wr_data[0]);
  c_refstby: cover property (stby == 2'h1);
endmodule

/* File: dv/sosc_tb.sv */
// Testbench: host and device ends joined by the link, host driven over
// Wishbone. Assumes a short settle wait parameter for simulation.
`timescale 1ns/1ps
module sosc_tb;
  localparam int SETTLE = 20;            // Short wake-up wait
  logic        clk, rst, ce;             // Clock, reset, enable
  logic        cyc, stb, we;             // Wishbone request
  logic [3:0]  adr, sel;                 // Address and byte selects
  logic [31:0] dat, dat_o, rd;           // Write, read, captured data
  logic        ack;                      // Wishbone answer
  logic [5:0]  pattern, hclk_out, hclk_oe_n;
  logic [13:0] pixel_in, pixel_data;
  logic        afe_on, ref_nodes_on, core_on, ref_buffer_on;
  logic [15:0] hcount;
  int          mismatches, n_compared, cycles;
  sosc_if lnk_if ();
  sosc_host #(.SETTLE_CYC(SETTLE)) sosc_host_inst (.clk(clk), .rst(rst),
    .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .lnk(lnk_if));
  sosc_device #(.HCOUNT_W(16)) sosc_device_inst (.clk(clk), .rst(rst),
    .ce(ce), .lnk(lnk_if), .pattern(pattern), .pixel_in(pixel_in),
    .hclk_out(hclk_out), .hclk_oe_n(hclk_oe_n), .pixel_data(pixel_data),
    .afe_on(afe_on), .ref_nodes_on(ref_nodes_on), .core_on(core_on),
    .ref_buffer_on(ref_buffer_on), .hcount(hcount));
  sosc_props #(.HCOUNT_W(16), .SETTLE_CYC(SETTLE)) sosc_props_inst (
    .clk(clk), .rst(rst), .wr_valid(lnk_if.wr_valid),
    .wr_addr(lnk_if.wr_addr), .wr_data(lnk_if.wr_data),
    .line_sync(lnk_if.line_sync), .frame_sync(lnk_if.frame_sync),
    .hclk_out(hclk_out), .hclk_oe_n(hclk_oe_n), .pixel_data(pixel_data),
    .afe_on(afe_on), .ref_nodes_on(ref_nodes_on), .core_on(core_on),
    .ref_buffer_on(ref_buffer_on), .hcount(hcount));
  // Free-running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Live core pattern never equals the idle level, so the two differ
  always @(posedge clk) begin
    pattern <= ~pattern;
    pixel_in <= pixel_in + 14'h1;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end
  // Verdict and end of run
  task complete_run();
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare one value, unknowns count as mismatches
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Let n edges pass, then sample where outputs have settled
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One classic Wishbone cycle; waits for ack, the cycle ceiling ends a hang
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Device register write: address word, then data word
  task link(input logic [11:0] a, input logic [27:0] d);
    wb(1'b1, 4'h8, {20'h0, a});
    wb(1'b1, 4'hc, {4'h0, d});
  endtask
  // Defaults after reset, and an unmapped read
  task t_reset();
    wait_n(1);
    chk(32'(hclk_oe_n), 32'h3f);
    chk(32'(pixel_data), 32'h0);
    chk(32'(ref_buffer_on), 32'h0);
    chk(32'(core_on), 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Leave shutdown; an early restart is dropped, a late one runs
  task t_wake();
    link(12'h000, 28'h0);
    link(12'h014, 28'h1);
    wait_n(2);
    chk(32'(core_on), 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk(32'(rd[1]), 32'h1);
    chk(32'(ref_buffer_on), 32'h1);
    wait_n(SETTLE);
    link(12'h014, 28'h0);
    link(12'h014, 28'h1);
    wait_n(2);
    chk(32'(core_on), 32'h1);
  endtask
  // Drive enable waits for a sync fall; frame then line sync are dropped
  task t_enable();
    wb(1'b1, 4'h0, 32'h7);
    link(12'h011, 28'h1);
    wait_n(8);
    chk(32'(hclk_out), 32'h0a);
    chk(32'(hclk_oe_n), 32'h0);
    wb(1'b1, 4'h0, 32'h5);
    wb(1'b1, 4'h0, 32'h1);
    wait_n(16);
    chk(32'(hclk_out), {26'h0, ~pattern});
  endtask
  // Every standby code with drive enable on, ending back in normal
  task t_modes();
    logic [7:0] codes;
    logic [1:0] c;
    codes = 8'h2d;
    for (int i = 0; i < 4; i++) begin
      c = codes[2*i +: 2];
      link(12'h000, {26'h0, c});
      wait_n(4);
      chk(32'(hclk_oe_n), c[1] ? 32'h3f : 32'h0);
      chk(32'(afe_on), 32'(c == 2'h0));
      chk(32'(ref_nodes_on), 32'(!c[1]));
      if (c == 2'h1) chk(32'(hclk_out), 32'h0a);
      if (c != 2'h0) chk(32'(pixel_data), 32'h0);
    end
    // Shutdown stopped the core: wait out the settle time, then restart
    wait_n(SETTLE);
    link(12'h014, 28'h0);
    link(12'h014, 28'h1);
    wait_n(2);
    chk(32'(core_on), 32'h1);
    chk(32'(hclk_out), {26'h0, ~pattern});
    chk(32'(pixel_data), {18'h0, pixel_in - 14'h1});
  endtask
  // Main sequence: reset held 3 cycles, then each scenario
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'hf;
    dat = 32'h0;
    pattern = 6'h15;
    pixel_in = 14'h0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wake();
    t_enable();
    t_modes();
    complete_run();
  end
endmodule

/* File: src/sosc_cfg.svh */
// Constants for the standby and output-state controller.
// Included by both ends; definitions only.
`ifndef SOSC_CFG_SVH
`define SOSC_CFG_SVH
// Device register offsets (12-bit address space)
`define SOSC_ADDR_STANDBY   12'h000
`define SOSC_ADDR_OUTCTL    12'h011
`define SOSC_ADDR_CORERST   12'h014
// Field positions inside the standby, output control and core restart registers
`define SOSC_STANDBY_LSB    0
`define SOSC_REFBUF_BIT     2
`define SOSC_OUTCTL_BIT     0
`define SOSC_CORERST_BIT    0
// Reset values
`define SOSC_STANDBY_RST    2'h3
`define SOSC_REFBUF_RST     1'h1
// Horizontal counter restart delay in master clock cycles
`define SOSC_HRESET_CYC     12
// Settle time before core restart, in microseconds, and clock rate in MHz
`define SOSC_SETTLE_US      100
`define SOSC_CLK_MHZ        250
`define SOSC_SETTLE_CYC     (`SOSC_SETTLE_US * `SOSC_CLK_MHZ)
// Host controller register offsets (byte addresses on Wishbone)
`define SOSC_WB_CTRL        4'h0
`define SOSC_WB_STAT        4'h4
`define SOSC_WB_WADDR       4'h8
`define SOSC_WB_WDATA       4'hc
`endif

/* File: src/sosc_device.sv */
// Device end: standby decode, output priority and timing core control.
// Assumes writes and syncs are synchronous to clk (the master clock).
`timescale 1ns/1ps
`include "sosc_cfg.svh"
module sosc_device
  import sosc_pkg::*;
#(
  parameter int HCOUNT_W = 16  // Horizontal counter width
) (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Link from host and sync source
  sosc_if.device                   lnk,
  // Live pattern from the timing core
  input  wire logic [5:0]          pattern,
  input  wire logic [13:0]         pixel_in,
  // Horizontal and reset-gate pins, enable low means driving
  output logic      [5:0]          hclk_out,
  output logic      [5:0]          hclk_oe_n,
  // Pixel data
  output logic      [13:0]         pixel_data,
  // Status
  output logic                     afe_on,
  output logic                     ref_nodes_on,
  output logic                     core_on,
  output logic                     ref_buffer_on,
  output logic      [HCOUNT_W-1:0] hcount
);

  // Pin order in hclk_out: 0..3 horizontal clocks 1..4, 4 last, 5 reset gate
  localparam logic [5:0] IDLE_LEVEL = 6'h0a;  // Clocks 2 and 4 high

  logic [1:0]          standby;      // Standby field
  logic                refbuf_pd;    // Reference buffer power-down
  logic                outctl_pend;  // Written drive enable
  logic                outctl;       // Applied drive enable
  logic                core_run;     // Timing core running
  logic                line_d;       // Previous line sync
  logic                frame_d;      // Previous frame sync
  logic [3:0]          hdelay;       // Countdown to counter reset
  logic                hdelay_act;   // Countdown in progress
  sosc_power_t         power;        // Decoded state
  logic [5:0]          next_hclk;
  logic [5:0]          next_hoe_n;
  logic [13:0]         next_pixel;
  logic [1:0]          next_standby;
  logic                next_refbuf_pd;
  logic                next_outctl_pend;
  logic                next_outctl;
  logic                next_core_run;
  logic [3:0]          next_hdelay;
  logic                next_hdelay_act;
  logic [HCOUNT_W-1:0] next_hcount;
  logic                line_fall;
  logic                frame_fall;

  // Standby decode
  always_comb begin
    case (standby)
      2'h0:    power = SOSC_NORMAL;
      2'h1:    power = SOSC_REF_STANDBY;
      default: power = SOSC_SHUTDOWN;
    endcase
  end

  assign line_fall  = line_d & ~lnk.line_sync;
  assign frame_fall = frame_d & ~lnk.frame_sync;

  // Register writes, sync-gated enable and core restart
  always_comb begin
    next_standby     = standby;
    next_refbuf_pd   = refbuf_pd;
    next_outctl_pend = outctl_pend;
    next_outctl      = outctl;
    next_core_run    = core_run;
    if (lnk.wr_valid) begin
      case (lnk.wr_addr)
        `SOSC_ADDR_STANDBY: begin
          // Takes effect at once, as power functions must
          next_standby   = lnk.wr_data[`SOSC_STANDBY_LSB +: 2];
          next_refbuf_pd = lnk.wr_data[`SOSC_REFBUF_BIT];
        end
        `SOSC_ADDR_OUTCTL: begin
          next_outctl_pend = lnk.wr_data[`SOSC_OUTCTL_BIT];
        end
        `SOSC_ADDR_CORERST: begin
          // A zero stops the core; a one restarts it
          next_core_run = lnk.wr_data[`SOSC_CORERST_BIT];
        end
        default: begin
          // Other registers belong to other blocks
        end
      endcase
    end
    // Drive enable applies only on a sync boundary so a field is not torn
    if (line_fall || frame_fall)
      next_outctl = next_outctl_pend;
    // Shutdown stops the timing core outright
    if (next_standby[1])
      next_core_run = 1'b0;
  end

  // Horizontal counter restart pipeline
  always_comb begin
    next_hdelay     = hdelay;
    next_hdelay_act = hdelay_act;
    next_hcount     = hcount + 1'b1;
    if (line_fall) begin
      // Count starts at the fall; reset lands on the twelfth edge
      next_hdelay     = 4'(`SOSC_HRESET_CYC - 1);
      next_hdelay_act = 1'b1;
    end else if (hdelay_act) begin
      if (hdelay == 4'h1) begin
        next_hdelay_act = 1'b0;
        next_hcount     = '0;
      end
      next_hdelay = hdelay - 4'h1;
    end
    if (!core_run)
      next_hcount = '0;
  end

  // Output states by priority: shutdown, then drive enable, then standby
  always_comb begin
    next_hclk  = IDLE_LEVEL;
    next_hoe_n = 6'h00;
    next_pixel = 14'h0000;
    if (power == SOSC_SHUTDOWN) begin
      next_hclk  = 6'h00;
      next_hoe_n = 6'h3f;
      next_pixel = 14'h0000;
    end else if (!outctl) begin
      next_hclk = IDLE_LEVEL;
    end else if (power == SOSC_REF_STANDBY) begin
      // Enable wins only in the sense that outputs stay idle-driven
      next_hclk = IDLE_LEVEL;
    end else if (core_run) begin
      next_hclk  = pattern;
      next_pixel = pixel_in;
    end
  end

  // Register all state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby     <= `SOSC_STANDBY_RST;
      refbuf_pd   <= `SOSC_REFBUF_RST;
      outctl_pend <= 1'b0;
      outctl      <= 1'b0;
      core_run    <= 1'b0;
      line_d      <= 1'b1;
      frame_d     <= 1'b1;
      hdelay      <= 4'h0;
      hdelay_act  <= 1'b0;
      hcount      <= '0;
      hclk_out    <= 6'h00;
      hclk_oe_n   <= 6'h3f;
      pixel_data  <= 14'h0000;
    end else if (ce) begin
      standby     <= next_standby;
      refbuf_pd   <= next_refbuf_pd;
      outctl_pend <= next_outctl_pend;
      outctl      <= next_outctl;
      core_run    <= next_core_run;
      line_d      <= lnk.line_sync;
      frame_d     <= lnk.frame_sync;
      hdelay      <= next_hdelay;
      hdelay_act  <= next_hdelay_act;
      hcount      <= next_hcount;
      hclk_out    <= next_hclk;
      hclk_oe_n   <= next_hoe_n;
      pixel_data  <= next_pixel;
    end
  end

  // Status views of the power state
  assign afe_on        = (power == SOSC_NORMAL);
  assign ref_nodes_on  = (power != SOSC_SHUTDOWN);
  assign core_on       = core_run;
  assign ref_buffer_on = ~refbuf_pd & (power != SOSC_SHUTDOWN);

endmodule

/* File: src/sosc_host.sv */
// Host end: Wishbone slave for software, drives writes and sync lines.
// Assumes a classic Wishbone master on clk; syncs come from the CTRL register bits.
`timescale 1ns/1ps
`include "sosc_cfg.svh"
module sosc_host
  import sosc_pkg::*;
#(
  parameter int SETTLE_CYC = `SOSC_SETTLE_CYC  // Wake-up settle wait
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Link to device
  sosc_if.host             lnk
);

  // CTRL: bit0 sync enable, bit1 frame level, bit2 line level
  // STAT: bit0 settle pending, bit1 core restart blocked
  logic [2:0]  ctrl;
  logic [11:0] waddr;
  logic [27:0] wdata;
  logic        wr_go;
  logic        line_lvl;
  logic        frame_lvl;
  logic [31:0] settle;
  logic        ack;
  logic [2:0]  next_ctrl;
  logic [11:0] next_waddr;
  logic [27:0] next_wdata;
  logic        next_wr_go;
  logic        next_line_lvl;
  logic        next_frame_lvl;
  logic [31:0] next_settle;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        req;
  logic        blocked;
  logic        wr_take;

  assign req = wb_cyc_i & wb_stb_i & ~ack;
  // Writes commit on the edge at which the master samples ack high
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack;
  // Core restart is held off while the wake settle time runs
  assign blocked = (waddr == `SOSC_ADDR_CORERST) && (settle != 32'h0);

  always_comb begin
    next_ctrl      = ctrl;
    next_waddr     = waddr;
    next_wdata     = wdata;
    next_wr_go     = 1'b0;
    next_ack       = req;
    next_dat       = 32'h0;
    next_settle    = (settle != 32'h0) ? settle - 32'h1 : settle;
    next_frame_lvl = ctrl[0] ? ctrl[1] : 1'b1;
    // Line may not fall before frame: it can fall on the same edge as frame, never earlier
    next_line_lvl  = ctrl[0] ? (ctrl[2] | (ctrl[1] & frame_lvl)) : 1'b1;
    if (wr_take) begin
      case (wb_adr_i)
        `SOSC_WB_CTRL:  if (wb_sel_i[0]) next_ctrl = wb_dat_i[2:0];
        `SOSC_WB_WADDR: next_waddr = wb_dat_i[11:0];
        `SOSC_WB_WDATA: begin
          next_wdata = wb_dat_i[27:0];
          next_wr_go = 1'b1;
          // Any standby write with bit 1 clear arms the settle timer, not only a wake from shutdown
          if (waddr == `SOSC_ADDR_STANDBY && !wb_dat_i[1])
            next_settle = 32'(SETTLE_CYC);
          if (waddr == `SOSC_ADDR_CORERST && settle != 32'h0)
            next_wr_go = 1'b0;
        end
        default: begin
        end
      endcase
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        `SOSC_WB_CTRL:  next_dat = {29'h0, ctrl};
        `SOSC_WB_STAT:  next_dat = {30'h0, blocked, settle != 32'h0};
        `SOSC_WB_WADDR: next_dat = {20'h0, waddr};
        `SOSC_WB_WDATA: next_dat = {4'h0, wdata};
        default:        next_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl      <= 3'h0;
      waddr     <= 12'h000;
      wdata     <= 28'h0;
      wr_go     <= 1'b0;
      line_lvl  <= 1'b1;
      frame_lvl <= 1'b1;
      settle    <= 32'h0;
      ack       <= 1'b0;
      wb_dat_o  <= 32'h0;
    end else if (ce) begin
      ctrl      <= next_ctrl;
      waddr     <= next_waddr;
      wdata     <= next_wdata;
      wr_go     <= next_wr_go;
      line_lvl  <= next_line_lvl;
      frame_lvl <= next_frame_lvl;
      settle    <= next_settle;
      ack       <= next_ack;
      wb_dat_o  <= next_dat;
    end
  end

  assign wb_ack_o       = ack;
  assign lnk.wr_valid   = wr_go;
  assign lnk.wr_addr    = waddr;
  assign lnk.wr_data    = wdata;
  assign lnk.line_sync  = line_lvl;
  assign lnk.frame_sync = frame_lvl;

endmodule

/* File: src/sosc_if.sv */
// Link between the host controller and the device end: a write port
// carrying address and data words, plus the two sync lines.
// Assumes both ends share clk, rst and the clock enable.
`timescale 1ns/1ps
interface sosc_if;
  logic        wr_valid;   // One-cycle register write strobe
  logic [11:0] wr_addr;    // Register address
  logic [27:0] wr_data;    // Register data
  logic        line_sync;  // Line sync, active low edge marks line
  logic        frame_sync; // Frame sync, active low edge marks frame

  modport device (
    input wr_valid,
    input wr_addr,
    input wr_data,
    input line_sync,
    input frame_sync
  );
  modport host (
    output wr_valid,
    output wr_addr,
    output wr_data,
    output line_sync,
    output frame_sync
  );
endinterface

/* File: src/sosc_pkg.sv */
// Types shared by both ends of the standby and output-state controller.
// Assumes sosc_cfg.svh is on the include path.
package sosc_pkg;
  // Decoded power state
  typedef enum logic [1:0] {
    SOSC_NORMAL,
    SOSC_REF_STANDBY,
    SOSC_SHUTDOWN
  } sosc_power_t;
endpackage
